// File: rtl/gate_drive_pkg.sv
// shared constants, register map and gate mapping for the three-phase gate drive logic
package gate_drive_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and timebase
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned TICK_NS = 100;
   localparam logic [4:0] TICK_CYCLES = 5'(TICK_NS * CLK_MHZ / 1000);

   ////////////////////////////////////////////////////////////////////////////////
   // timing, figures in ns, counts in ticks
   localparam int unsigned DRIVE_DELAY_NS = 3000;
   localparam int unsigned HIGH_TURNON_DEAD_TIME_NS = 3000;
   localparam int unsigned LOW_TURNON_DEAD_TIME_NS = 3000;
   localparam int unsigned LIMIT_DETECT_LATENCY_NS = 1500;
   localparam logic [5:0] DRIVE_DELAY_TICKS = 6'((DRIVE_DELAY_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [5:0] HIGH_DEAD_TICKS =
      6'((HIGH_TURNON_DEAD_TIME_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [5:0] LOW_DEAD_TICKS = 6'((LOW_TURNON_DEAD_TIME_NS + TICK_NS - 1) / TICK_NS);
   localparam logic [5:0] LIMIT_TICKS = 6'((LIMIT_DETECT_LATENCY_NS + TICK_NS - 1) / TICK_NS);

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] INT_STATUS_OFFSET = 4'h8;
   localparam logic [3:0] INT_MASK_OFFSET = 4'hC;
   localparam logic CTRL_RESET = 1'h1;
   localparam logic [4:0] INT_MASK_RESET = 5'h00;

   // error / event bit positions, shared by status, int status and int mask; the await bit and gate fields are in status only
   localparam int unsigned ERR_OVERTEMP_BIT = 0;
   localparam int unsigned ERR_OVERVOLT_BIT = 1;
   localparam int unsigned ERR_CURLIM_BIT = 2;
   localparam int unsigned ERR_FUSE_BIT = 3;
   localparam int unsigned ERR_SUPPLY_BIT = 4;
   localparam int unsigned STAT_AWAIT_BIT = 5;
   localparam int unsigned STAT_HIGH_LSB = 8;
   localparam int unsigned STAT_LOW_LSB = 12;

   ////////////////////////////////////////////////////////////////////////////////
   // wanted gates of one phase, {high, low}
   function automatic logic [1:0] phase_want(input logic [1:0] mode, input logic hse,
                                             input logic lse, input logic pwm);
      logic [1:0] want;
      want = 2'h0;
      if (hse && !lse)
      begin
         case (mode)
            2'h0: want = 2'h2;
            2'h1: want = 2'h2;
            2'h2: want = {pwm, 1'b0};
            default: want = {pwm, ~pwm};
         endcase
      end
      else if (lse && !hse)
      begin
         case (mode)
            2'h0: want = {1'b0, pwm};
            2'h1: want = {~pwm, pwm};
            2'h2: want = 2'h1;
            default: want = 2'h1;
         endcase
      end
      return want;
   endfunction

endpackage

// File: rtl/pin_sync.sv
// two flip-flop synchroniser bank for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(parameter int unsigned WIDTH = 8)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pin_async,
   output logic [WIDTH-1:0] pin_synced
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         stage1_reg <= '0;
         pin_synced <= '0;
      end
      else
      begin
         stage1_reg <= pin_async;
         pin_synced <= stage1_reg;
      end
   end
endmodule
`default_nettype wire

// File: rtl/phase_dead_time.sv
// one phase: dead-time guarded high and low gate commands
`timescale 1ns/100ps
`default_nettype none
module phase_dead_time
   import gate_drive_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic tick,
   input wire logic want_high,
   input wire logic want_low,
   output logic high_gate_cmd,
   output logic low_gate_cmd
);
   logic [5:0] high_cnt_reg;
   logic [5:0] low_cnt_reg;
   wire high_hold = !want_high || low_gate_cmd;
   wire low_hold = !want_low || high_gate_cmd;
   wire high_ready = (high_cnt_reg == HIGH_DEAD_TICKS) && !low_gate_cmd;
   wire low_ready = (low_cnt_reg == LOW_DEAD_TICKS) && !high_gate_cmd;

   ////////////////////////////////////////////////////////////////////////////////
   // turn-off at once, turn-on only after the opposite gate stayed off
   always_ff @(posedge clk_sys)
   begin
      if (reset || high_hold)
         high_cnt_reg <= 6'h00;
      else if (tick && !high_ready)
         high_cnt_reg <= high_cnt_reg + 6'h01; // [R2] [R14]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset || low_hold)
         low_cnt_reg <= 6'h00;
      else if (tick && !low_ready)
         low_cnt_reg <= low_cnt_reg + 6'h01; // [R2] [R14]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         high_gate_cmd <= 1'b0;
         low_gate_cmd <= 1'b0;
      end
      else
      begin
         high_gate_cmd <= want_high && (high_gate_cmd || high_ready); // [R14] [R18]
         low_gate_cmd <= want_low && (low_gate_cmd || low_ready); // [R14] [R18]
      end
   end
endmodule
`default_nettype wire

// File: rtl/three_phase_gate_drive_logic.sv
// top: mode mapping, fault latches, timebase and avalon register slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// [R1] gates switch 3 us after pwm edge
// [R2] complementary chop alternates, each turn-on delayed
// [R3] overtemp/overvolt latch drives off till next cycle
// [R4] current limit latched off till next cycle
// [R5] controller toggles pwm to re-enable drives
// [R6] blown fuse forces all gates off forever
// [R7] comparator trip sets limit bit, stops current
// [R8] overtemp/overvolt set error bit, stop current
// [R9] each phase uses own pair; equal means off
// [R10] mode 00: high steady, low chops
// [R11] mode 10: high chops, low steady
// [R12] mode 01: high steady, low complementary chop
// [R13] mode 11: high complementary chop, low steady
// [R14] dead time keeps both switches apart
// [R15] comparator low for latency sets limit
// [R16] low logic supply keeps drives off
// [R17] limit kills chopped gates, overfaults kill all
// [R18] complementary: one follows pwm, other inverse
module three_phase_gate_drive_logic
   import gate_drive_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic pwm_in,
   input wire logic chop_select_bit0,
   input wire logic chop_select_bit1,
   input wire logic [2:0] high_side_enable_in,
   input wire logic [2:0] low_side_enable_in,
   input wire logic overtemp_flag,
   input wire logic overvolt_flag,
   input wire logic current_sense_n,
   input wire logic supply_fuse_blown,
   input wire logic logic_supply_low,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [2:0] high_gate_cmd,
   output logic [2:0] low_gate_cmd,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [13:0] pins_synced;
   logic pwm_sync;
   logic [1:0] mode_sync;
   logic [2:0] hse_sync;
   logic [2:0] lse_sync;
   logic ot_sync;
   logic ov_sync;
   logic sense_n_sync;
   logic fuse_sync;
   logic supply_low_sync;

   pin_sync #(.WIDTH(14)) u_pin_sync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_async({pwm_in, chop_select_bit1, chop_select_bit0, high_side_enable_in,
                  low_side_enable_in, overtemp_flag, overvolt_flag, current_sense_n,
                  supply_fuse_blown, logic_supply_low}),
      .pin_synced(pins_synced)
   );

   assign pwm_sync = pins_synced[13];
   assign mode_sync = pins_synced[12:11];
   assign hse_sync = pins_synced[10:8];
   assign lse_sync = pins_synced[7:5];
   assign ot_sync = pins_synced[4];
   assign ov_sync = pins_synced[3];
   assign sense_n_sync = pins_synced[2];
   assign fuse_sync = pins_synced[1];
   assign supply_low_sync = pins_synced[0];

   ////////////////////////////////////////////////////////////////////////////////
   // timebase: one-cycle tick every TICK_CYCLES clocks
   logic [4:0] div_reg;
   logic tick_reg;
   wire div_wrap = (div_reg == TICK_CYCLES - 5'h01);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         div_reg <= 5'h00;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_wrap ? 5'h00 : div_reg + 5'h01;
         tick_reg <= div_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pwm edges and delayed copy that the gates follow
   logic pwm_prev_reg;
   logic pwm_applied_reg;
   logic delay_pending_reg;
   logic [5:0] delay_cnt_reg;
   wire pwm_edge = pwm_sync ^ pwm_prev_reg;
   wire pwm_rise = pwm_sync && !pwm_prev_reg;
   wire delay_done = delay_pending_reg && tick_reg && (delay_cnt_reg == 6'h01);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         pwm_prev_reg <= 1'b0;
      else
         pwm_prev_reg <= pwm_sync;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         delay_pending_reg <= 1'b0;
         delay_cnt_reg <= 6'h00;
      end
      else if (pwm_edge)
      begin
         delay_pending_reg <= 1'b1; // [R1]
         delay_cnt_reg <= DRIVE_DELAY_TICKS;
      end
      else if (delay_done)
         delay_pending_reg <= 1'b0;
      else if (delay_pending_reg && tick_reg)
         delay_cnt_reg <= delay_cnt_reg - 6'h01; // [R1]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         pwm_applied_reg <= 1'b0;
      else if (delay_done)
         pwm_applied_reg <= pwm_sync; // [R1]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // current-sense qualification
   logic [5:0] limit_cnt_reg;
   wire limit_trip = (limit_cnt_reg == LIMIT_TICKS);

   always_ff @(posedge clk_sys)
   begin
      if (reset || sense_n_sync)
         limit_cnt_reg <= 6'h00;
      else if (tick_reg && !limit_trip)
         limit_cnt_reg <= limit_cnt_reg + 6'h01; // [R15]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // error latches, cleared by the next pwm cycle start; the fuse latch only by reset
   logic ot_latch_reg;
   logic ov_latch_reg;
   logic cl_latch_reg;
   logic fuse_latch_reg;
   logic await_toggle_reg;
   logic supply_low_prev_reg;

   wire ot_next = ot_sync || (ot_latch_reg && !pwm_rise); // [R3] [R8]
   wire ov_next = ov_sync || (ov_latch_reg && !pwm_rise); // [R3] [R8]
   wire cl_next = limit_trip || (cl_latch_reg && !pwm_rise); // [R4] [R7] [R15]
   wire fuse_next = fuse_sync || fuse_latch_reg; // [R6]
   // power-up and supply dips wait for a fresh pwm cycle
   wire await_next = supply_low_sync || (await_toggle_reg && !pwm_rise); // [R5] [R16]

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ot_latch_reg <= 1'b0;
      else
         ot_latch_reg <= ot_next; // [R3] [R8]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         ov_latch_reg <= 1'b0;
      else
         ov_latch_reg <= ov_next; // [R3] [R8]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         cl_latch_reg <= 1'b0;
      else
         cl_latch_reg <= cl_next; // [R4] [R7]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         fuse_latch_reg <= 1'b0;
      else
         fuse_latch_reg <= fuse_next; // [R6]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         await_toggle_reg <= 1'b1;
      else
         await_toggle_reg <= await_next; // [R5] [R16]
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         supply_low_prev_reg <= 1'b0;
      else
         supply_low_prev_reg <= supply_low_sync;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // gate mapping per phase
   logic drive_enable_reg;
   wire all_off = fuse_latch_reg || ot_latch_reg || ov_latch_reg || supply_low_sync
                  || await_toggle_reg || !drive_enable_reg; // [R3] [R6] [R16] [R17]
   // limit holds pwm low: chopped turn-ons go, inverse chopped gates turn on, steady gates stay
   wire pwm_eff = pwm_applied_reg && !cl_latch_reg; // [R4] [R7] [R17]
   logic [2:0] want_high;
   logic [2:0] want_low;

   for (genvar ph = 0; ph < 3; ph++)
   begin : g_phase
      wire [1:0] want = phase_want(mode_sync, hse_sync[ph], lse_sync[ph], pwm_eff); // [R9]
      // [R10] [R11] [R12] [R13] [R18]
      assign want_high[ph] = want[1] && !all_off;
      assign want_low[ph] = want[0] && !all_off;

      phase_dead_time u_phase
      (
         .clk_sys(clk_sys),
         .reset(reset),
         .tick(tick_reg),
         .want_high(want_high[ph]),
         .want_low(want_low[ph]),
         .high_gate_cmd(high_gate_cmd[ph]),
         .low_gate_cmd(low_gate_cmd[ph])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // events into sticky interrupt status
   logic [4:0] int_status_reg;
   logic [4:0] int_mask_reg;

   // a latch or level that is about to rise
   function automatic logic rose_now(input logic level_next, input logic level_now);
      return level_next && !level_now;
   endfunction

   wire [4:0] events = {rose_now(supply_low_sync, supply_low_prev_reg),
                        rose_now(fuse_next, fuse_latch_reg),
                        rose_now(cl_next, cl_latch_reg),
                        rose_now(ov_next, ov_latch_reg),
                        rose_now(ot_next, ot_latch_reg)};

   ////////////////////////////////////////////////////////////////////////////////
   // avalon slave: waitrequest drops one cycle after the request
   wire req = avs_read || avs_write;
   wire accept = req && !avs_waitrequest;
   wire wr_lane0 = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire sel_ctrl = (avs_address == CTRL_OFFSET);
   wire sel_status = (avs_address == STATUS_OFFSET);
   wire sel_int = (avs_address == INT_STATUS_OFFSET);
   wire sel_mask = (avs_address == INT_MASK_OFFSET);
   wire [4:0] int_clear = (wr_lane0 && sel_int) ? avs_writedata[4:0] : 5'h00;
   // set wins over a simultaneous clear
   wire [4:0] int_status_next = (int_status_reg & ~int_clear) | events;

   wire [31:0] status_word = {16'h0000, 1'b0, low_gate_cmd, 1'b0, high_gate_cmd, 2'h0,
                              await_toggle_reg, supply_low_sync, fuse_latch_reg,
                              cl_latch_reg, ov_latch_reg, ot_latch_reg};
   wire [31:0] read_mux = sel_ctrl ? {31'h0, drive_enable_reg} :
                          sel_status ? status_word :
                          sel_int ? {27'h0, int_status_reg} :
                          sel_mask ? {27'h0, int_mask_reg} : 32'h00000000;

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !(req && avs_waitrequest) || accept;
   end

   // captured with the request, stands in the answer cycle
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         avs_readdata <= 32'h00000000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= read_mux;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control and mask registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         drive_enable_reg <= CTRL_RESET;
      else if (wr_lane0 && sel_ctrl)
         drive_enable_reg <= avs_writedata[0];
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         int_mask_reg <= INT_MASK_RESET;
      else if (wr_lane0 && sel_mask)
         int_mask_reg <= avs_writedata[4:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sticky status and level interrupt
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         int_status_reg <= 5'h00;
      else
         int_status_reg <= int_status_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(int_status_next & int_mask_reg);
   end

endmodule
`default_nettype wire

// File: dv/gate_drive_checker.sv
// concurrent checks on the gate drive logic ports
`timescale 1ns/100ps
`default_nettype none
module gate_drive_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic overtemp_flag,
   input wire logic overvolt_flag,
   input wire logic supply_fuse_blown,
   input wire logic logic_supply_low,
   input wire logic [2:0] high_side_enable_in,
   input wire logic [2:0] low_side_enable_in,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [2:0] high_gate_cmd,
   input wire logic [2:0] low_gate_cmd,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic [7:0] lo_off_reg;
   wire logic [5:0] gates = {high_gate_cmd, low_gate_cmd};
   // cycles the phase 0 low gate has been off, saturating
   always_ff @(posedge clk_sys)
   begin
      if (reset || low_gate_cmd[0])
         lo_off_reg <= 8'h00;
      else if (lo_off_reg != 8'hFF)
         lo_off_reg <= lo_off_reg + 8'h01;
   end
   AST_NO_SHOOT: assert property ((high_gate_cmd & low_gate_cmd) == 3'h0)
      else $error("high and low gate on together");
   AST_DEAD_HIGH: assert property ($rose(high_gate_cmd[0]) |-> lo_off_reg >= 8'hC8)
      else $error("high gate on without dead time");
   AST_FAULT_OFF: assert property ((overtemp_flag || overvolt_flag) [*5]
      |-> gates == 6'h00)
      else $error("gates on during fault");
   AST_SUPPLY_OFF: assert property (logic_supply_low [*5] |-> gates == 6'h00)
      else $error("gates on with low supply");
   AST_FUSE_OFF: assert property (supply_fuse_blown [*5] |-> gates == 6'h00)
      else $error("gates on with fuse blown");
   AST_EQUAL_OFF: assert property ((high_side_enable_in[2] == low_side_enable_in[2]) [*5]
      |-> !high_gate_cmd[2] && !low_gate_cmd[2])
      else $error("equal pair drives a gate");
   AST_RESET_STATE: assert property (disable iff (1'b0) reset
      |=> gates == 6'h00 && !irq && avs_waitrequest)
      else $error("outputs wrong after reset");
   AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one wait cycle");
   COV_FAULT: cover property (overtemp_flag ##1 gates == 6'h00);
   COV_CHOP: cover property ($fell(low_gate_cmd[0]) ##[1:1000] $rose(high_gate_cmd[0]));
   COV_IRQ: cover property ($rose(irq));
endmodule
bind three_phase_gate_drive_logic gate_drive_checker u_chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .overtemp_flag(overtemp_flag),
   .overvolt_flag(overvolt_flag),
   .supply_fuse_blown(supply_fuse_blown),
   .logic_supply_low(logic_supply_low),
   .high_side_enable_in(high_side_enable_in),
   .low_side_enable_in(low_side_enable_in),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .high_gate_cmd(high_gate_cmd),
   .low_gate_cmd(low_gate_cmd),
   .irq(irq)
);
`default_nettype wire

// File: dv/mcu_pwm_model.sv
// pwm source standing in for the motor controller
`timescale 1ns/100ps
`default_nettype none
module mcu_pwm_model #(parameter int HALF = 1500)
(
   input wire logic clk_sys,
   input wire logic run,
   output logic pwm_in
);
   int cnt = 0;
   initial pwm_in = 1'b0;
   // keeps toggling so the drive re-arms after faults
   always @(posedge clk_sys)
   begin
      cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
      if (run && cnt == HALF - 1)
         pwm_in <= ~pwm_in;
   end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the gate drive logic
`timescale 1ns/100ps
`default_nettype none
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic run = 1'b0;
   logic pwm_in, wait_req, irq, cl;
   logic [1:0] mode = 2'h0;
   logic [2:0] hse = 3'h0, lse = 3'h0, hg, lg;
   logic ot = 1'b0, ov = 1'b0, sense_n = 1'b1, fuse = 1'b0, vlow = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0, wr = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   int mismatches = 0;
   int n_checks = 0;
   three_phase_gate_drive_logic dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .pwm_in(pwm_in),
      .chop_select_bit0(mode[0]),
      .chop_select_bit1(mode[1]),
      .high_side_enable_in(hse),
      .low_side_enable_in(lse),
      .overtemp_flag(ot),
      .overvolt_flag(ov),
      .current_sense_n(sense_n),
      .supply_fuse_blown(fuse),
      .logic_supply_low(vlow),
      .avs_address(addr),
      .avs_read(rd),
      .avs_write(wr),
      .avs_writedata(wdata),
      .avs_byteenable(4'hF),
      .avs_readdata(rdata),
      .avs_waitrequest(wait_req),
      .high_gate_cmd(hg),
      .low_gate_cmd(lg),
      .irq(irq)
   );
   mcu_pwm_model mcu (
      .clk_sys(clk_sys),
      .run(run),
      .pwm_in(pwm_in)
   );
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      rd <= !w;
      wr <= w;
      @(posedge clk_sys);
      while (wait_req !== 1'b0)
         @(posedge clk_sys);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // {high, low} of one phase
   function automatic logic [1:0] want(input logic [1:0] m, input logic h, input logic l,
                                       input logic p);
      if (h == l)
         return 2'h0;
      if (h)
         return (m[1] == 1'b0) ? 2'h2 : {p, m[0] & ~p};
      return (m[1] == 1'b1) ? 2'h1 : {m[0] & ~p, p};
   endfunction
   task automatic at_pwm(input logic lvl, input int n);
      if (lvl)
         @(posedge pwm_in);
      else
         @(negedge pwm_in);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk_gates(input logic p);
      logic [5:0] e;
      for (int i = 0; i < 3; i++)
         {e[i+3], e[i]} = want(mode, hse[i], lse[i], p & ~cl);
      `CK("gates", e, {hg, lg})
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (95000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cl = 1'b0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      hse <= 3'h5;
      lse <= 3'h6;
      bus(1'b0, 4'h0, 32'h0);
      `CK("ctrl", 32'h1, d)
      bus(1'b0, 4'hC, 32'h0);
      `CK("mask", 32'h0, d)
      bus(1'b1, 4'h2, 32'hFFFFFFFF);
      bus(1'b0, 4'h2, 32'h0);
      `CK("unmapped", 32'h0, d)
      repeat (1500) @(posedge clk_sys);
      bus(1'b0, 4'h4, 32'h0);
      `CK("status", 32'h20, d)
      `CK("idle", 6'h00, {hg, lg})
      run <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         mode <= m[1:0];
         @(posedge pwm_in);
         at_pwm(1'b1, 790);
         if (m == 0)
            `CK("delay", 1'b0, lg[1])
         repeat (610) @(posedge clk_sys);
         chk_gates(1'b1);
         at_pwm(1'b0, 1400);
         chk_gates(1'b0);
      end
      mode <= 2'h0;
      at_pwm(1'b1, 100);
      sense_n <= 1'b0;
      repeat (200) @(posedge clk_sys);
      bus(1'b0, 4'h4, 32'h0);
      `CK("limit", 1'b0, d[2])
      repeat (700) @(posedge clk_sys);
      bus(1'b0, 4'h4, 32'h0);
      `CK("limit", 1'b1, d[2])
      cl = 1'b1;
      repeat (300) @(posedge clk_sys);
      chk_gates(1'b1);
      bus(1'b0, 4'h8, 32'h0);
      `CK("events", 32'h4, d)
      `CK("irq", 1'b0, irq)
      bus(1'b1, 4'hC, 32'h4);
      repeat (3) @(posedge clk_sys);
      `CK("irq", 1'b1, irq)
      sense_n <= 1'b1;
      at_pwm(1'b0, 1400);
      bus(1'b0, 4'h4, 32'h0);
      `CK("limit", 1'b1, d[2])
      cl = 1'b0;
      at_pwm(1'b1, 1400);
      chk_gates(1'b1);
      bus(1'b1, 4'h8, 32'h4);
      repeat (3) @(posedge clk_sys);
      `CK("irq", 1'b0, irq)
      mode <= 2'h2;
      at_pwm(1'b1, 1400);
      for (int i = 0; i < 2; i++)
      begin
         {ov, ot} <= 2'h1 << i;
         repeat (10) @(posedge clk_sys);
         `CK("fault", 6'h00, {hg, lg})
         bus(1'b0, 4'h4, 32'h0);
         `CK("fault", 1'b1, d[i])
         {ov, ot} <= 2'h0;
         at_pwm(1'b0, 1400);
         `CK("held", 6'h00, {hg, lg})
         at_pwm(1'b1, 1400);
         chk_gates(1'b1);
      end
      bus(1'b1, 4'h0, 32'h0);
      repeat (5) @(posedge clk_sys);
      `CK("disable", 6'h00, {hg, lg})
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      `CK("ctrl", 32'h1, d)
      vlow <= 1'b1;
      repeat (10) @(posedge clk_sys);
      `CK("supply", 6'h00, {hg, lg})
      bus(1'b0, 4'h4, 32'h0);
      `CK("supply", 1'b1, d[4])
      vlow <= 1'b0;
      fuse <= 1'b1;
      repeat (10) @(posedge clk_sys);
      fuse <= 1'b0;
      at_pwm(1'b1, 0);
      at_pwm(1'b1, 1400);
      `CK("fuse", 6'h00, {hg, lg})
      bus(1'b0, 4'h4, 32'h0);
      `CK("fuse", 1'b1, d[3])
      tally_and_finish;
   end
endmodule
`default_nettype wire
